// >>> hw/rx_term_link_defines.vh
`ifndef RX_TERM_LINK_DEFINES_VH
`define RX_TERM_LINK_DEFINES_VH

// ----------------------------------------------------------------------
// Register port widths
// ----------------------------------------------------------------------
`define ADDR_W            12
`define DATA_W            8

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define OFS_TERM_CFG_A0   12'h2aa
`define OFS_TERM_CFG_B0   12'h2ab
`define OFS_TERM_CAL_G2   12'h2ae
`define OFS_TERM_CFG_A1   12'h2b1
`define OFS_TERM_CFG_B1   12'h2b2
`define OFS_RX_GEN_CTRL   12'h300
`define OFS_CHK_CMP_0     12'h40e
`define OFS_CHK_CMP_1     12'h416
`define OFS_CHK_CMP_2     12'h41e
`define OFS_CHK_CMP_3     12'h42e
`define OFS_CHK_CMP_4     12'h43e
`define OFS_CHK_CMP_5     12'h446
`define OFS_PACKED_HI     8'h45
`define PACKED_LAST       4'ha
`define PACKED_NUM        11

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_TERM_CFG_A    8'hc3
`define RST_TERM_CFG_B    8'h93
`define RST_ZERO          8'h00

// ----------------------------------------------------------------------
// Field positions in the general receiver control and calibration trigger registers
// ----------------------------------------------------------------------
`define BIT_CHK_MODE      6
`define BIT_LINK_MODE     3
`define BIT_LINK_PAGE     2
`define BIT_LINK_EN1      1
`define BIT_LINK_EN0      0
`define MASK_RX_GEN_CTRL  8'h4f
`define BIT_CAL_TRIGGER   0

// Writable bits of packed config bytes 10 down to 0, others read zero
`define PACKED_MASK       88'h9f_ff_ff_df_ff_1f_ff_9f_7f_ff_ff

`endif

// >>> hw/link_checksum.v
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Link parameter checksum of one link's packed configuration bytes
// ----------------------------------------------------------------------
module link_checksum (
    input  wire [87:0] packed_cfg,
    input  wire        method_sum_bytes,
    output reg  [7:0]  checksum
);

    reg [7:0] byte_sum;
    reg [7:0] field_sum;
    reg [7:0] b [0:10];
    integer   i;

    // Byte view and both sums, each taken modulo 256
    always @* begin
        byte_sum  = 8'h00;
        for (i = 0; i < 11; i = i + 1) begin
            b[i]     = packed_cfg[i*8 +: 8];
            byte_sum = byte_sum + b[i];
        end
        // Sum of individual fields in the standard table order
        field_sum = b[0]                                   // Device id
                  + {4'h0, b[1][3:0]} + {4'h0, b[1][7:4]}  // Bank, adj count
                  + {3'h0, b[2][4:0]}                      // Lane id
                  + {7'h00, b[2][5]} + {7'h00, b[2][6]}    // Phase adj, dir
                  + {3'h0, b[3][4:0]} + {7'h00, b[3][7]}   // Lanes, scramble
                  + b[4]                                   // Octets/frame
                  + {3'h0, b[5][4:0]}                      // Frames/multi
                  + b[6]                                   // Converters
                  + {3'h0, b[7][4:0]} + {6'h00, b[7][7:6]} // Resolution, ctrl
                  + {3'h0, b[8][4:0]} + {5'h00, b[8][7:5]} // Width, subclass
                  + {3'h0, b[9][4:0]} + {5'h00, b[9][7:5]} // Samples, version
                  + {3'h0, b[10][4:0]} + {7'h00, b[10][7]}; // Ctrl words, HD
        if (method_sum_bytes) begin
            checksum = byte_sum;
        end else begin
            checksum = field_sum;
        end
    end

endmodule // link_checksum

// >>> hw/rx_term_link_regs.v
// Behaviour
// - Rising edge of lane-group-2 calibration bit calibrates lanes 2-5.
// - Computed checksum is held in six compare registers 0x40E..0x446.
// - Checksum method 0 sums individual link configuration fields.
// - Checksum method 1 sums packed bytes 0x450..0x45A modulo 256.
// - Bit 3 picks single (0) or dual (1) link, reset 0.
// - Bit 2 pages addresses 0x401..0x47E between link 0 and 1.
// - Bits 1:0 enable link 1 and link 0 receivers, set last.
`timescale 1ns/1ps
`include "rx_term_link_defines.vh"

module rx_term_link_regs (
    input  wire              ref_clk,
    input  wire              rst,
    input  wire [11:0]       reg_addr,
    input  wire              reg_wr,
    input  wire [7:0]        reg_wdata,
    input  wire              reg_rd,
    output reg  [7:0]        reg_rdata_ff,
    output reg  [7:0]        term_cfg_a0_ff,
    output reg  [7:0]        term_cfg_b0_ff,
    output reg  [7:0]        term_cfg_a1_ff,
    output reg  [7:0]        term_cfg_b1_ff,
    output reg               lane_group2_cal_start_ff,
    output reg  [1:0]        link_enable_ff,
    output reg               dual_link_ff,
    output reg               checksum_mode_ff,
    output reg               link_page_ff,
    output reg  [7:0]        checksum_link0_ff,
    output reg  [7:0]        checksum_link1_ff
);

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    reg  [7:0]  pk0_ff [0:10];   // Packed config, link 0
    reg  [7:0]  pk1_ff [0:10];   // Packed config, link 1
    reg         lane_group2_term_cal_trigger_ff;
    reg         cal_prev_ff;
    reg  [87:0] pk0_flat;
    reg  [87:0] pk1_flat;
    wire [7:0]  chk0;
    wire [7:0]  chk1;
    wire        pk_hit;
    wire [3:0]  pk_idx;
    reg  [7:0]  nxt_rdata;
    reg  [7:0]  pk_mask;
    wire [87:0] pk_mask_all;
    integer     fl_i;        // Flatten loop index
    integer     mk_i;        // Mask loop index
    integer     rs_i;        // Reset loop index

    assign pk_hit = (reg_addr[11:4] == `OFS_PACKED_HI) &&
                    (reg_addr[3:0] <= `PACKED_LAST);
    assign pk_idx = reg_addr[3:0];
    assign pk_mask_all = `PACKED_MASK;

    // Flatten packed bytes for the checksum units
    always @* begin
        pk0_flat = 88'h0;
        pk1_flat = 88'h0;
        for (fl_i = 0; fl_i < `PACKED_NUM; fl_i = fl_i + 1) begin
            pk0_flat[fl_i*8 +: 8] = pk0_ff[fl_i];
            pk1_flat[fl_i*8 +: 8] = pk1_ff[fl_i];
        end
    end

    // Writable bit mask of the addressed packed byte
    always @* begin
        pk_mask = `RST_ZERO;
        for (mk_i = 0; mk_i < `PACKED_NUM; mk_i = mk_i + 1) begin
            if (pk_idx == mk_i[3:0]) begin
                pk_mask = pk_mask_all[mk_i*8 +: 8];
            end
        end
    end

    // ------------------------------------------------------------------
    // Checksum units, one per link
    // ------------------------------------------------------------------
    link_checksum u_chk0 (
        .packed_cfg       (pk0_flat),
        .method_sum_bytes (checksum_mode_ff),
        .checksum         (chk0)
    );

    link_checksum u_chk1 (
        .packed_cfg       (pk1_flat),
        .method_sum_bytes (checksum_mode_ff),
        .checksum         (chk1)
    );

    // ------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------
    // Termination, calibration and control registers
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            term_cfg_a0_ff             <= `RST_TERM_CFG_A;
            term_cfg_b0_ff             <= `RST_TERM_CFG_B;
            term_cfg_a1_ff             <= `RST_TERM_CFG_A;
            term_cfg_b1_ff             <= `RST_TERM_CFG_B;
            lane_group2_term_cal_trigger_ff <= 1'b0;
            checksum_mode_ff           <= 1'b0;
            dual_link_ff               <= 1'b0;
            link_page_ff               <= 1'b0;
            link_enable_ff             <= 2'b00;
        end else if (reg_wr) begin
            case (reg_addr)
                `OFS_TERM_CFG_A0: term_cfg_a0_ff <= reg_wdata;
                `OFS_TERM_CFG_B0: term_cfg_b0_ff <= reg_wdata;
                `OFS_TERM_CFG_A1: term_cfg_a1_ff <= reg_wdata;
                `OFS_TERM_CFG_B1: term_cfg_b1_ff <= reg_wdata;
                `OFS_TERM_CAL_G2: begin
                    // Upper bits are reserved and dropped
                    lane_group2_term_cal_trigger_ff <=
                        reg_wdata[`BIT_CAL_TRIGGER];
                end
                `OFS_RX_GEN_CTRL: begin
                    // Method bit steers both checksum units
                    checksum_mode_ff <= reg_wdata[`BIT_CHK_MODE];
                    dual_link_ff     <= reg_wdata[`BIT_LINK_MODE];
                    link_page_ff     <= reg_wdata[`BIT_LINK_PAGE];
                    link_enable_ff   <=
                        reg_wdata[`BIT_LINK_EN1:`BIT_LINK_EN0];
                end
                default: begin
                end
            endcase
        end
    end

    // Packed configuration bytes, steered by the page bit
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (rs_i = 0; rs_i < `PACKED_NUM; rs_i = rs_i + 1) begin
                pk0_ff[rs_i] <= `RST_ZERO;
                pk1_ff[rs_i] <= `RST_ZERO;
            end
        end else if (reg_wr && pk_hit) begin
            if (link_page_ff) begin
                pk1_ff[pk_idx] <= reg_wdata & pk_mask;
            end else begin
                pk0_ff[pk_idx] <= reg_wdata & pk_mask;
            end
        end
    end

    // ------------------------------------------------------------------
    // Calibration trigger edge
    // ------------------------------------------------------------------
    // One-cycle start pulse on a 0 to 1 change of the stored bit only
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cal_prev_ff              <= 1'b0;
            lane_group2_cal_start_ff <= 1'b0;
        end else begin
            cal_prev_ff              <= lane_group2_term_cal_trigger_ff;
            lane_group2_cal_start_ff <= lane_group2_term_cal_trigger_ff &
                                        ~cal_prev_ff;
        end
    end

    // ------------------------------------------------------------------
    // Checksum compare storage
    // ------------------------------------------------------------------
    // Locally computed checksums are captured every cycle
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            checksum_link0_ff <= `RST_ZERO;
            checksum_link1_ff <= `RST_ZERO;
        end else begin
            checksum_link0_ff <= chk0;
            checksum_link1_ff <= chk1;
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    // Read value mux; unmapped addresses read zero
    always @* begin
        nxt_rdata = `RST_ZERO;
        if (pk_hit) begin
            nxt_rdata = link_page_ff ? pk1_ff[pk_idx]
                                     : pk0_ff[pk_idx];
        end else begin
            case (reg_addr)
                `OFS_TERM_CFG_A0: nxt_rdata = term_cfg_a0_ff;
                `OFS_TERM_CFG_B0: nxt_rdata = term_cfg_b0_ff;
                `OFS_TERM_CFG_A1: nxt_rdata = term_cfg_a1_ff;
                `OFS_TERM_CFG_B1: nxt_rdata = term_cfg_b1_ff;
                `OFS_TERM_CAL_G2: begin
                    nxt_rdata = {7'h00,
                                 lane_group2_term_cal_trigger_ff};
                end
                `OFS_RX_GEN_CTRL: begin
                    nxt_rdata = {1'b0, checksum_mode_ff, 2'b00,
                                 dual_link_ff, link_page_ff,
                                 link_enable_ff};
                end
                `OFS_CHK_CMP_0, `OFS_CHK_CMP_1, `OFS_CHK_CMP_2,
                `OFS_CHK_CMP_3, `OFS_CHK_CMP_4, `OFS_CHK_CMP_5: begin
                    nxt_rdata = link_page_ff ? checksum_link1_ff
                                             : checksum_link0_ff;
                end
                default: nxt_rdata = `RST_ZERO;
            endcase
        end
    end

    // Registered read data, held until the next read
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            reg_rdata_ff <= `RST_ZERO;
        end else if (reg_rd) begin
            reg_rdata_ff <= nxt_rdata;
        end
    end

endmodule // rx_term_link_regs

// >>> dv/rx_term_link_regs_asserts.sv
`timescale 1ns/1ps

module rx_term_link_regs_chk (
    input wire        ref_clk,
    input wire        rst,
    input wire [11:0] reg_addr,
    input wire        reg_wr,
    input wire [7:0]  reg_wdata,
    input wire        reg_rd,
    input wire [7:0]  reg_rdata_ff,
    input wire [7:0]  term_cfg_a0_ff,
    input wire        lane_group2_cal_start_ff,
    input wire [1:0]  link_enable_ff,
    input wire        dual_link_ff,
    input wire        checksum_mode_ff,
    input wire        link_page_ff,
    input wire [7:0]  checksum_link0_ff,
    input wire [7:0]  checksum_link1_ff
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    // Write to the general receiver control register
    sequence s_ctrl_wr;
        reg_wr && reg_addr == 12'h300;
    endsequence

    // Control fields follow the written byte one cycle later
    a_link_mode: assert property (
        s_ctrl_wr |=> dual_link_ff == $past(reg_wdata[3]))
        else $error("link mode not taken");
    a_link_page: assert property (
        s_ctrl_wr |=> link_page_ff == $past(reg_wdata[2]))
        else $error("page not taken");
    a_sum_mode: assert property (
        s_ctrl_wr |=> checksum_mode_ff == $past(reg_wdata[6]))
        else $error("checksum mode not taken");
    a_link_enable: assert property (
        s_ctrl_wr |=> link_enable_ff == $past(reg_wdata[1:0]))
        else $error("link enable not taken");
    a_ctrl_hold: assert property (
        !(reg_wr && reg_addr == 12'h300) |=>
        $stable({dual_link_ff, link_page_ff, link_enable_ff}))
        else $error("control changed without write");

    // Calibration start is a lone pulse caused by a write of one
    a_cal_single: assert property (
        lane_group2_cal_start_ff |=> !lane_group2_cal_start_ff)
        else $error("calibration pulse too long");
    a_cal_cause: assert property (
        lane_group2_cal_start_ff |-> $past(reg_wr, 2) &&
        $past(reg_addr, 2) == 12'h2ae && $past(reg_wdata[0], 2))
        else $error("calibration pulse without write");

    // Reads of compare and unmapped places, write of a termination place
    a_cmp_read: assert property (
        reg_rd && reg_addr == 12'h446 |=> reg_rdata_ff ==
        ($past(link_page_ff) ? $past(checksum_link1_ff)
                             : $past(checksum_link0_ff)))
        else $error("compare read wrong");
    a_unmapped_rd: assert property (
        reg_rd && reg_addr == 12'h7ff |=> reg_rdata_ff == 8'h00)
        else $error("unmapped read not zero");
    a_term_write: assert property (
        reg_wr && reg_addr == 12'h2aa |=>
        term_cfg_a0_ff == $past(reg_wdata))
        else $error("termination write lost");
endmodule // rx_term_link_regs_chk

bind rx_term_link_regs rx_term_link_regs_chk i_chk (
    .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata_ff(reg_rdata_ff), .term_cfg_a0_ff(term_cfg_a0_ff),
    .lane_group2_cal_start_ff(lane_group2_cal_start_ff),
    .link_enable_ff(link_enable_ff), .dual_link_ff(dual_link_ff),
    .checksum_mode_ff(checksum_mode_ff), .link_page_ff(link_page_ff),
    .checksum_link0_ff(checksum_link0_ff),
    .checksum_link1_ff(checksum_link1_ff));

// >>> dv/tb_top.sv
`timescale 1ns/1ps
`include "rx_term_link_defines.vh"

module tb_top;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic [11:0] reg_addr = 12'h000;
    logic        reg_wr = 1'b0;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_rd = 1'b0;
    wire  [7:0]  rdata, ta0, tb0, ta1, tb1, ck0, ck1;
    wire  [1:0]  link_en;
    wire         cal, dual, cmode, page;
    integer      num_errors = 0, check_count = 0, seed = 43567;
    integer      pulses = 0, i, j, v, s, ctl;
    integer      pk [0:1][0:10];
    logic [11:0] cmp [$] = '{12'h40e, 12'h416, 12'h41e,
                               12'h42e, 12'h43e, 12'h446};

    // Clock and calibration pulse counter
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (cal === 1'b1) pulses = pulses + 1;

    rx_term_link_regs i_dut (
        .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
        .reg_rdata_ff(rdata), .term_cfg_a0_ff(ta0),
        .term_cfg_b0_ff(tb0), .term_cfg_a1_ff(ta1),
        .term_cfg_b1_ff(tb1), .lane_group2_cal_start_ff(cal),
        .link_enable_ff(link_en), .dual_link_ff(dual),
        .checksum_mode_ff(cmode), .link_page_ff(page),
        .checksum_link0_ff(ck0), .checksum_link1_ff(ck1));

    // Compare, register write and register read
    task automatic chk(input [7:0] g, input [7:0] e);
        check_count = check_count + 1;
        if (g !== e) begin
            num_errors = num_errors + 1;
            $display("unexpected at %0t: got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wr(input [11:0] a, input [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge ref_clk) #1;
        reg_wr = 1'b0;
        @(posedge ref_clk) #1;
    endtask
    task automatic rd(input [11:0] a, input [7:0] e);
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge ref_clk) #1;
        reg_rd = 1'b0;
        chk(rdata, e);
        @(posedge ref_clk) #1;
    endtask

    // Reference checksum of one link: field sum or byte sum
    function automatic integer csum(input integer l, input integer m);
        logic [7:0] b [0:10];
        integer     k, t;
        t = 0;
        for (k = 0; k < 11; k = k + 1) begin
            b[k] = pk[l][k];
            t = t + b[k];
        end
        if (m == 0)
            t = b[0] + b[1][7:4] + b[1][3:0] + b[2][6] + b[2][5]
              + b[2][4:0] + b[3][7] + b[3][4:0] + b[4] + b[5][4:0]
              + b[6] + b[7][7:6] + b[7][4:0] + b[8][7:5] + b[8][4:0]
              + b[9][7:5] + b[9][4:0] + b[10][7] + b[10][4:0];
        return t % 256;
    endfunction

    task automatic complete_run;
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Watchdog
    initial begin
        #100000;
        num_errors = num_errors + 1;
        complete_run;
    end

    // Main sequence
    initial begin
        repeat (20) @(posedge ref_clk);
        #1 rst = 1'b0;
        rd(12'h2aa, 8'hc3);
        rd(12'h2b1, 8'hc3);
        rd(12'h2ab, 8'h93);
        rd(12'h2b2, 8'h93);
        rd(12'h300, 8'h00);
        wr(12'h2aa, 8'hb7);
        wr(12'h2b1, 8'hb7);
        wr(12'h2ab, 8'h87);
        wr(12'h2b2, 8'h87);
        chk(ta0, 8'hb7);
        chk(ta1, 8'hb7);
        chk(tb0, 8'h87);
        chk(tb1, 8'h87);
        wr(12'h2ae, 8'hff);
        rd(12'h2ae, 8'h01);
        wr(12'h2ae, 8'h01);
        wr(12'h2ae, 8'h00);
        wr(12'h2ae, 8'h01);
        rd(12'h2ae, 8'h01);
        chk(pulses[7:0], 8'h02);
        rd(12'h7ff, 8'h00);
        for (i = 0; i < 8; i = i + 1) begin
            ctl = $random(seed) & 8'hff;
            wr(12'h300, ctl[7:0]);
            rd(12'h300, ctl[7:0] & 8'h4f);
            chk({1'b0, cmode, 2'b00, dual, page, link_en},
                ctl[7:0] & 8'h4f);
        end
        for (j = 0; j < 4; j = j + 1) begin
            ctl = ((j & 1) << 2) | ((j >> 1) << 6);
            wr(12'h300, ctl[7:0]);
            for (i = 0; i < 11; i = i + 1) begin
                v = $random(seed) & ((`PACKED_MASK >> (8 * i)) & 8'hff);
                pk[j & 1][i] = v;
                wr(12'h450 + i[11:0], v[7:0]);
                rd(12'h450 + i[11:0], v[7:0]);
            end
            s = csum(j & 1, j >> 1);
            for (i = 0; i < cmp.size(); i = i + 1) rd(cmp[i], s[7:0]);
            chk((j & 1) ? ck1 : ck0, s[7:0]);
        end
        wr(12'h300, 8'h40);
        s = csum(0, 1);
        wr(12'h40e, ~s[7:0]);
        rd(12'h40e, s[7:0]);
        wr(12'h300, 8'h00);
        s = csum(0, 0);
        rd(12'h41e, s[7:0]);
        complete_run;
    end
endmodule // tb_top
